// file: mfe_pkg.sv
// Shared constants for the multidrop serial command front end.
package mfe_pkg;

   // Register byte offsets on the APB bus.
   localparam logic [7:0] MFE_OFS_CARD    = 8'h00;
   localparam logic [7:0] MFE_OFS_ADDRM   = 8'h04;
   localparam logic [7:0] MFE_OFS_ERRREP  = 8'h08;
   localparam logic [7:0] MFE_OFS_STATUS  = 8'h0C;
   localparam logic [7:0] MFE_OFS_LASTERR = 8'h10;

   // Setting widths and reset values.
   localparam int         MFE_CARD_W      = 4;
   localparam int         MFE_MODE_W      = 2;
   localparam int         MFE_ERRREP_W    = 2;
   localparam int         MFE_CODE_W      = 5;
   localparam logic [3:0] MFE_CARD_RST    = 4'h0;
   localparam logic [1:0] MFE_MODE_RST    = 2'h0;
   localparam logic [1:0] MFE_ERRREP_RST  = 2'h0;
   localparam logic [1:0] MFE_MODE_ADDR   = 2'h2;
   localparam logic [3:0] MFE_CARD_MASTER = 4'h0;

   // Status register bit positions.
   localparam int MFE_ST_ADDRESSED = 0;
   localparam int MFE_ST_BCAST     = 1;
   localparam int MFE_ST_SHUTDOWN  = 2;
   localparam int MFE_ST_JUMPER    = 3;
   localparam int MFE_ST_RESP      = 4;

   // Character codes.
   localparam logic [7:0] MFE_CH_CR    = 8'h0D;
   localparam logic [7:0] MFE_CH_SPACE = 8'h20;
   localparam logic [7:0] MFE_CH_AT    = 8'h40;
   localparam logic [7:0] MFE_CH_LA    = 8'h61;
   localparam logic [7:0] MFE_CH_LZ    = 8'h7A;
   localparam logic [7:0] MFE_CH_CASE  = 8'h20;
   localparam logic [7:0] MFE_CH_D0    = 8'h30;
   localparam logic [7:0] MFE_CH_D9    = 8'h39;
   localparam logic [7:0] MFE_CH_UA    = 8'h41;
   localparam logic [7:0] MFE_CH_UF    = 8'h46;
   localparam logic [7:0] MFE_HEX_OFS  = 8'h37;

   // Error codes.
   localparam logic [4:0] MFE_ERR_NONE    = 5'h00;
   localparam logic [4:0] MFE_ERR_PROG    = 5'h01;
   localparam logic [4:0] MFE_ERR_SYNTAX  = 5'h03;
   localparam logic [4:0] MFE_ERR_CHAR    = 5'h04;
   localparam logic [4:0] MFE_ERR_NOBUF   = 5'h05;
   localparam logic [4:0] MFE_ERR_BUFFULL = 5'h06;
   localparam logic [4:0] MFE_ERR_BUFOPEN = 5'h07;
   localparam logic [4:0] MFE_ERR_STRUCT  = 5'h09;
   localparam logic [4:0] MFE_ERR_LIMITS  = 5'h0A;
   localparam logic [4:0] MFE_ERR_MOVING  = 5'h0B;
   localparam logic [4:0] MFE_ERR_OPENLP  = 5'h0C;
   localparam logic [4:0] MFE_ERR_INACT   = 5'h0D;
   localparam logic [4:0] MFE_ERR_NOMOT   = 5'h0E;
   localparam logic [4:0] MFE_ERR_RUNSTR  = 5'h10;

   // Command class bits supplied by the downstream interpreter.
   localparam int MFE_CLS_W        = 7;
   localparam int MFE_CLS_BAD      = 0;
   localparam int MFE_CLS_PROGLOCK = 1;
   localparam int MFE_CLS_NEEDBUF  = 2;
   localparam int MFE_CLS_OPENBUF  = 3;
   localparam int MFE_CLS_BUFWR    = 4;
   localparam int MFE_CLS_MOVE     = 5;
   localparam int MFE_CLS_RUN      = 6;

   // Fault flag bits supplied by the motion side.
   localparam int MFE_FLT_W       = 10;
   localparam int MFE_FLT_RUNNING = 0;
   localparam int MFE_FLT_BUFOPEN = 1;
   localparam int MFE_FLT_BUFFULL = 2;
   localparam int MFE_FLT_STRENT  = 3;
   localparam int MFE_FLT_STRRUN  = 4;
   localparam int MFE_FLT_BUSY    = 5;
   localparam int MFE_FLT_NOMOT   = 6;
   localparam int MFE_FLT_INACT   = 7;
   localparam int MFE_FLT_OPENLP  = 8;
   localparam int MFE_FLT_LIMITS  = 9;

   // Clock watchdog timing.
   localparam int MFE_CLK_HZ        = 250_000_000;
   localparam int MFE_WDOG_ABSENT_US = 1000;

   typedef enum logic [1:0] {
      MFE_LN_START,
      MFE_LN_AT,
      MFE_LN_SEL,
      MFE_LN_CMD
   } mfe_line_e;

endpackage : mfe_pkg

// file: mfe_err_pri.sv
// Priority encoder that turns a command class and fault flags into an error code.
`timescale 1ns/1ns
module mfe_err_pri
   import mfe_pkg::*;
(
   input  wire logic [mfe_pkg::MFE_CLS_W-1:0]  cls,
   input  wire logic [mfe_pkg::MFE_FLT_W-1:0]  flt,
   output logic      [mfe_pkg::MFE_CODE_W-1:0] code
);

   // Program lock comes first so a running program is never disturbed by later checks.
   always_comb
   begin
      code = MFE_ERR_NONE;
      if (cls[MFE_CLS_PROGLOCK] && flt[MFE_FLT_RUNNING])
         code = MFE_ERR_PROG;
      else if (cls[MFE_CLS_BAD])
         code = MFE_ERR_SYNTAX;
      else if (cls[MFE_CLS_NEEDBUF] && !flt[MFE_FLT_BUFOPEN])
         code = MFE_ERR_NOBUF;
      else if (cls[MFE_CLS_OPENBUF] && flt[MFE_FLT_BUFOPEN])
         code = MFE_ERR_BUFOPEN;
      else if (cls[MFE_CLS_BUFWR] && flt[MFE_FLT_BUFFULL])
         code = MFE_ERR_BUFFULL;
      else if (cls[MFE_CLS_BUFWR] && flt[MFE_FLT_STRENT])
         code = MFE_ERR_STRUCT;
      else if (cls[MFE_CLS_RUN] && flt[MFE_FLT_STRRUN])
         code = MFE_ERR_RUNSTR;
      else if (cls[MFE_CLS_MOVE])
      begin
         if (flt[MFE_FLT_BUSY])
            code = MFE_ERR_MOVING;
         else if (flt[MFE_FLT_NOMOT])
            code = MFE_ERR_NOMOT;
         else if (flt[MFE_FLT_INACT])
            code = MFE_ERR_INACT;
         else if (flt[MFE_FLT_OPENLP])
            code = MFE_ERR_OPENLP;
         else if (flt[MFE_FLT_LIMITS])
            code = MFE_ERR_LIMITS;
      end
   end

endmodule : mfe_err_pri

// file: mfe_frontend.sv
// Serial command front end: card addressing, character filtering, errors, clock watchdog.
`timescale 1ns/1ns
module mfe_frontend
   import mfe_pkg::*;
#(
   parameter int WDOG_CYCLES = (mfe_pkg::MFE_CLK_HZ / 1_000_000) * mfe_pkg::MFE_WDOG_ABSENT_US
)
(
   input  wire logic                               pclk,
   input  wire logic                               presetn,
   input  wire logic                               psel,
   input  wire logic                               penable,
   input  wire logic                               pwrite,
   input  wire logic [7:0]                         paddr,
   input  wire logic [31:0]                        pwdata,
   output logic                                    pready,
   output logic      [31:0]                        prdata,
   output logic                                    pslverr,
   input  wire logic                               rx_valid,
   input  wire logic [7:0]                         rx_data,
   input  wire logic                               rx_parity_err,
   input  wire logic                               rx_frame_err,
   output logic                                    cmd_char_valid,
   output logic      [7:0]                         cmd_char,
   output logic                                    cmd_end,
   output logic                                    ctrl_cmd_valid,
   output logic      [7:0]                         ctrl_cmd,
   output logic                                    resp_enable,
   input  wire logic                               cls_valid,
   input  wire logic [mfe_pkg::MFE_CLS_W-1:0]      cls_bits,
   input  wire logic [mfe_pkg::MFE_FLT_W-1:0]      fault_flags,
   output logic                                    err_valid,
   output logic      [mfe_pkg::MFE_CODE_W-1:0]     err_code,
   output logic      [mfe_pkg::MFE_ERRREP_W-1:0]   err_form,
   input  wire logic                               external_clock_jumper,
   input  wire logic                               servo_clk_in,
   input  wire logic                               phase_clk_in,
   output logic                                    shutdown,
   output logic                                    fault_led
);
   import mfe_pkg::*;

   localparam int WD_W = $clog2(WDOG_CYCLES + 1);
   localparam logic [WD_W-1:0] WD_LIMIT = WD_W'(WDOG_CYCLES);

   // Folds a lower-case letter to upper case; everything else passes unchanged.
   function automatic logic [7:0] mfe_fold(input logic [7:0] c);
      logic [7:0] r;
      r = c;
      if (c >= MFE_CH_LA && c <= MFE_CH_LZ)
         r = c - MFE_CH_CASE;
      return r;
   endfunction : mfe_fold

   // Returns a hex digit value in the low bits and a valid flag in bit 4.
   function automatic logic [4:0] mfe_hex(input logic [7:0] c);
      logic [7:0] v;
      logic       ok;
      v  = 8'h00;
      ok = 1'b0;
      if (c >= MFE_CH_D0 && c <= MFE_CH_D9)
      begin
         v  = c - MFE_CH_D0;
         ok = 1'b1;
      end
      else if (c >= MFE_CH_UA && c <= MFE_CH_UF)
      begin
         v  = c - MFE_HEX_OFS;
         ok = 1'b1;
      end
      return {ok, v[3:0]};
   endfunction : mfe_hex

   // Settings and status state.
   logic [MFE_CARD_W-1:0]   card_number_setting_q;
   logic [MFE_MODE_W-1:0]   addressing_mode_setting_q;
   logic [MFE_ERRREP_W-1:0] error_report_setting_q;
   logic [MFE_CODE_W-1:0]   last_err_q;
   logic                    addressed_q;
   logic                    bcast_q;
   logic                    pready_q;
   logic [31:0]             prdata_q;
   logic                    pslverr_q;

   // Line parser state.
   mfe_line_e               line_q;
   logic                    line_bad_q;
   logic                    sel_bcast_q;
   logic [MFE_CARD_W-1:0]   sel_num_q;
   logic                    cmd_char_valid_q;
   logic [7:0]              cmd_char_q;
   logic                    cmd_end_q;
   logic                    ctrl_cmd_valid_q;
   logic [7:0]              ctrl_cmd_q;
   logic                    resp_enable_q;
   logic                    err_valid_q;
   logic [MFE_CODE_W-1:0]   err_code_q;

   // Watchdog state.
   logic [2:0]              jmp_sync_q;
   logic [2:0]              servo_sync_q;
   logic [2:0]              phase_sync_q;
   logic [WD_W-1:0]         servo_cnt_q;
   logic [WD_W-1:0]         phase_cnt_q;
   logic                    shutdown_q;

   logic                    addr_required;
   logic                    listening;
   logic                    respond_ok;
   logic                    char_bad;
   logic [7:0]              ch_up;
   logic [4:0]              ch_hex;
   logic                    sel_apply;
   logic                    parse_err3;
   logic [MFE_CODE_W-1:0]   cls_code;
   logic [MFE_CODE_W-1:0]   evt_code;
   logic                    apb_acc;
   logic                    apb_done;

   assign addr_required = addressing_mode_setting_q >= MFE_MODE_ADDR;
   assign listening     = !addr_required || addressed_q;
   assign respond_ok    = !addr_required ||
                          (addressed_q && (!bcast_q ||
                           card_number_setting_q == MFE_CARD_MASTER));
   assign char_bad      = rx_data[7] || rx_parity_err || rx_frame_err;
   assign ch_up         = mfe_fold(rx_data);
   assign ch_hex        = mfe_hex(ch_up);
   assign sel_apply     = rx_valid && !char_bad && rx_data == MFE_CH_CR &&
                          line_q == MFE_LN_SEL && !line_bad_q;
   assign apb_acc       = psel && penable;
   assign apb_done      = apb_acc && pready_q;

   // Select-command syntax faults: '@' with nothing usable behind it, or any further character above space after the selector.
   always_comb
   begin
      parse_err3 = 1'b0;
      if (rx_valid && !char_bad && !line_bad_q)
      begin
         if (rx_data == MFE_CH_CR)
            parse_err3 = line_q == MFE_LN_AT;
         else if (rx_data >= MFE_CH_SPACE && rx_data != MFE_CH_SPACE)
            parse_err3 = (line_q == MFE_LN_AT && ch_up != MFE_CH_AT && !ch_hex[4]) ||
                         line_q == MFE_LN_SEL;
      end
   end

   mfe_err_pri u_err_pri
   (
      .cls  (cls_bits),
      .flt  (fault_flags),
      .code (cls_code)
   );

   // Character faults outrank parser faults, which outrank interpreter faults.
   always_comb
   begin
      evt_code = MFE_ERR_NONE;
      if (rx_valid && char_bad)
         evt_code = MFE_ERR_CHAR;
      else if (parse_err3)
         evt_code = MFE_ERR_SYNTAX;
      else if (cls_valid)
         evt_code = cls_code;
   end

   // APB slave with one wait state so that read data comes from a flip-flop.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pready_q  <= apb_acc && !pready_q;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         if (apb_acc && !pready_q)
         begin
            case (paddr)
               MFE_OFS_CARD:    prdata_q <= 32'(card_number_setting_q);
               MFE_OFS_ADDRM:   prdata_q <= 32'(addressing_mode_setting_q);
               MFE_OFS_ERRREP:  prdata_q <= 32'(error_report_setting_q);
               MFE_OFS_STATUS:
               begin
                  prdata_q[MFE_ST_ADDRESSED] <= addressed_q;
                  prdata_q[MFE_ST_BCAST]     <= bcast_q;
                  prdata_q[MFE_ST_SHUTDOWN]  <= shutdown_q;
                  prdata_q[MFE_ST_JUMPER]    <= jmp_sync_q[1];
                  prdata_q[MFE_ST_RESP]      <= respond_ok;
               end
               MFE_OFS_LASTERR: prdata_q <= 32'(last_err_q);
               default:         pslverr_q <= 1'b1;
            endcase
         end
      end
   end

   // Software settings; writes land at the edge where the access completes.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         card_number_setting_q     <= MFE_CARD_RST;
         addressing_mode_setting_q <= MFE_MODE_RST;
         error_report_setting_q    <= MFE_ERRREP_RST;
      end
      else if (apb_done && pwrite)
      begin
         case (paddr)
            MFE_OFS_CARD:   card_number_setting_q     <= pwdata[MFE_CARD_W-1:0];
            MFE_OFS_ADDRM:  addressing_mode_setting_q <= pwdata[MFE_MODE_W-1:0];
            MFE_OFS_ERRREP: error_report_setting_q    <= pwdata[MFE_ERRREP_W-1:0];
            default:        card_number_setting_q     <= card_number_setting_q;
         endcase
      end
   end

   // Card addressing state, changed only by a complete select line.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         addressed_q <= 1'b0;
         bcast_q     <= 1'b0;
      end
      else if (sel_apply)
      begin
         if (sel_bcast_q)
         begin
            addressed_q <= 1'b1;
            bcast_q     <= 1'b1;
         end
         else if (sel_num_q == card_number_setting_q)
         begin
            addressed_q <= 1'b1;
            bcast_q     <= 1'b0;
         end
         else
         begin
            addressed_q <= 1'b0;
            bcast_q     <= 1'b0;
         end
      end
   end

   // Line parser. A bad character poisons the rest of the line until the carriage return.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         line_q      <= MFE_LN_START;
         line_bad_q  <= 1'b0;
         sel_bcast_q <= 1'b0;
         sel_num_q   <= MFE_CARD_RST;
      end
      else if (rx_valid)
      begin
         if (rx_data == MFE_CH_CR && !char_bad)
         begin
            line_q     <= MFE_LN_START;
            line_bad_q <= 1'b0;
         end
         else if (char_bad || parse_err3)
            line_bad_q <= 1'b1;
         else if (rx_data > MFE_CH_SPACE && !line_bad_q)
         begin
            case (line_q)
               MFE_LN_START:
                  line_q <= (ch_up == MFE_CH_AT) ? MFE_LN_AT : MFE_LN_CMD;
               MFE_LN_AT:
               begin
                  line_q      <= MFE_LN_SEL;
                  sel_bcast_q <= ch_up == MFE_CH_AT;
                  sel_num_q   <= ch_hex[3:0];
               end
               MFE_LN_SEL:
                  line_q <= MFE_LN_SEL;
               MFE_LN_CMD:
                  line_q <= MFE_LN_CMD;
               default:
                  line_q <= MFE_LN_START;
            endcase
         end
      end
   end

   // Outgoing character stream and control actions.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmd_char_valid_q <= 1'b0;
         cmd_char_q       <= 8'h00;
         cmd_end_q        <= 1'b0;
         ctrl_cmd_valid_q <= 1'b0;
         ctrl_cmd_q       <= 8'h00;
      end
      else
      begin
         cmd_char_valid_q <= 1'b0;
         cmd_end_q        <= 1'b0;
         ctrl_cmd_valid_q <= 1'b0;
         if (rx_valid && !char_bad)
         begin
            if (rx_data == MFE_CH_CR)
               cmd_end_q <= line_q == MFE_LN_CMD && listening && !line_bad_q;
            else if (rx_data < MFE_CH_SPACE)
            begin
               ctrl_cmd_valid_q <= 1'b1;
               ctrl_cmd_q       <= rx_data;
            end
            else if (rx_data != MFE_CH_SPACE && listening && !line_bad_q &&
                     (line_q == MFE_LN_CMD ||
                      (line_q == MFE_LN_START && ch_up != MFE_CH_AT)))
            begin
               cmd_char_valid_q <= 1'b1;
               cmd_char_q       <= ch_up;
            end
         end
      end
   end

   // Error reporting. The last code is always logged; the report pulse obeys the setting.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         err_valid_q   <= 1'b0;
         err_code_q    <= MFE_ERR_NONE;
         last_err_q    <= MFE_ERR_NONE;
         resp_enable_q <= 1'b0;
      end
      else
      begin
         resp_enable_q <= respond_ok && !shutdown_q;
         err_valid_q   <= 1'b0;
         if (evt_code != MFE_ERR_NONE)
         begin
            last_err_q <= evt_code;
            if (error_report_setting_q != MFE_ERRREP_RST && respond_ok)
            begin
               err_valid_q <= 1'b1;
               err_code_q  <= evt_code;
            end
         end
      end
   end

   // Pin synchronisers: the first stage feeds only the second.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         jmp_sync_q   <= 3'h0;
         servo_sync_q <= 3'h0;
         phase_sync_q <= 3'h0;
      end
      else
      begin
         jmp_sync_q   <= {jmp_sync_q[1:0], external_clock_jumper};
         servo_sync_q <= {servo_sync_q[1:0], servo_clk_in};
         phase_sync_q <= {phase_sync_q[1:0], phase_clk_in};
      end
   end

   // Clock watchdog. Shutdown latches until reset, since a board that lost sync must not resume.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         servo_cnt_q <= '0;
         phase_cnt_q <= '0;
         shutdown_q  <= 1'b0;
      end
      else
      begin
         if (!jmp_sync_q[1] || servo_sync_q[2] != servo_sync_q[1])
            servo_cnt_q <= '0;
         else if (servo_cnt_q != WD_LIMIT)
            servo_cnt_q <= servo_cnt_q + 1'b1;
         if (!jmp_sync_q[1] || phase_sync_q[2] != phase_sync_q[1])
            phase_cnt_q <= '0;
         else if (phase_cnt_q != WD_LIMIT)
            phase_cnt_q <= phase_cnt_q + 1'b1;
         if (servo_cnt_q == WD_LIMIT || phase_cnt_q == WD_LIMIT)
            shutdown_q <= 1'b1;
      end
   end

   assign pready         = pready_q;
   assign prdata         = prdata_q;
   assign pslverr        = pslverr_q;
   assign cmd_char_valid = cmd_char_valid_q;
   assign cmd_char       = cmd_char_q;
   assign cmd_end        = cmd_end_q;
   assign ctrl_cmd_valid = ctrl_cmd_valid_q;
   assign ctrl_cmd       = ctrl_cmd_q;
   assign resp_enable    = resp_enable_q;
   assign err_valid      = err_valid_q;
   assign err_code       = err_code_q;
   assign err_form       = error_report_setting_q;
   assign shutdown       = shutdown_q;
   assign fault_led      = shutdown_q;

endmodule : mfe_frontend

// file: mfe_host.sv
// Host model driving characters onto the serial receive side.
`timescale 1ns/1ns
module mfe_host
(
   input  wire logic       pclk,
   input  wire logic       go,
   input  wire logic [9:0] ch,
   output logic            rx_valid,
   output logic      [7:0] rx_data,
   output logic            rx_parity_err,
   output logic            rx_frame_err
);
   // Idle lines toggle so a stale character is never taken for a fresh one.
   always_ff @(posedge pclk)
   begin
      rx_valid <= go;
      {rx_frame_err, rx_parity_err, rx_data} <= go ? ch : ~{rx_frame_err, rx_parity_err, rx_data};
   end
endmodule : mfe_host

// file: mfe_frontend_checker.sv
// Port assertions for the serial command front end.
`timescale 1ns/1ns
module mfe_frontend_checker
   import mfe_pkg::*;
(
   input wire logic pclk, presetn, psel, penable, pready, rx_valid, rx_parity_err,
   input wire logic rx_frame_err, cmd_char_valid, ctrl_cmd_valid, resp_enable, cls_valid,
   input wire logic err_valid, shutdown, fault_led,
   input wire logic [7:0] rx_data, cmd_char, ctrl_cmd,
   input wire logic [mfe_pkg::MFE_CLS_W-1:0] cls_bits,
   input wire logic [mfe_pkg::MFE_FLT_W-1:0] fault_flags,
   input wire logic [mfe_pkg::MFE_CODE_W-1:0] err_code,
   input wire logic [mfe_pkg::MFE_ERRREP_W-1:0] err_form
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   apb_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
      else $error("apb wait state wrong");
   fold_case_a: assert property (cmd_char_valid |-> cmd_char == ($past(rx_data) inside
      {[MFE_CH_LA:MFE_CH_LZ]} ? $past(rx_data) - MFE_CH_CASE : $past(rx_data)))
      else $error("case fold wrong");
   no_space_a: assert property (cmd_char_valid |-> cmd_char != MFE_CH_SPACE)
      else $error("space passed");
   char_err_a: assert property (rx_valid && (rx_data[7] || rx_parity_err || rx_frame_err)
      && err_form != 0 && resp_enable |=> err_valid && err_code == MFE_ERR_CHAR)
      else $error("char error missed");
   ctrl_pass_a: assert property (rx_valid && rx_data < MFE_CH_SPACE && rx_data != MFE_CH_CR
      && !rx_parity_err && !rx_frame_err |=> ctrl_cmd_valid && ctrl_cmd == $past(rx_data))
      else $error("control char lost");
   report_gate_a: assert property (err_valid |-> err_form != 0 && err_code != 0)
      else $error("error sent while off");
   prog_lock_a: assert property (cls_valid && !rx_valid && cls_bits == (1 << MFE_CLS_PROGLOCK)
      && fault_flags[MFE_FLT_RUNNING] && err_form != 0 && resp_enable
      |=> err_valid && err_code == MFE_ERR_PROG)
      else $error("program lock missed");
   shut_hold_a: assert property (shutdown |=> shutdown && fault_led)
      else $error("shutdown dropped");
   cover property (cmd_char_valid);
   cover property (err_valid);
   cover property ($rose(shutdown));
endmodule : mfe_frontend_checker

bind mfe_frontend mfe_frontend_checker mfe_frontend_checker_i (.*);

// file: multidrop_serial_command_frontend_test.sv
// Self-checking bench for the serial command front end.
`timescale 1ns/1ns
module multidrop_serial_command_frontend_test;
   import mfe_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go, cls_valid, cmd_end;
   logic rx_valid, rx_parity_err, rx_frame_err, cmd_char_valid, ctrl_cmd_valid, resp_enable;
   logic err_valid, external_clock_jumper, servo_clk_in, phase_clk_in, shutdown, fault_led;
   logic [7:0] paddr, rx_data, cmd_char, ctrl_cmd;
   logic [31:0] pwdata, prdata, seed;
   logic [32:0] rd;
   logic [9:0] ch;
   logic [MFE_CLS_W-1:0] cls_bits;
   logic [MFE_FLT_W-1:0] fault_flags;
   logic [MFE_CODE_W-1:0] err_code;
   logic [MFE_ERRREP_W-1:0] err_form;
   int failures, n_checks, c;
   int cb[12] = '{1, 0, 2, 3, 4, 4, 6, 5, 5, 5, 5, 5};
   int fb[12] = '{0, -1, -1, 1, 2, 3, 4, 5, 6, 7, 8, 9};
   int ec[12] = '{1, 3, 5, 7, 6, 9, 16, 11, 14, 13, 12, 10};
   mfe_frontend #(.WDOG_CYCLES(50)) mfe_frontend_i (.*);
   mfe_host mfe_host_i (.*);
   initial
   begin
      pclk = 0;
      forever #2 pclk = ~pclk;
   end
   task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1);
      rd = {pslverr, prdata};
      {psel, penable} <= 0;
   endtask : apb
   task automatic tx(input logic [9:0] b, input logic [2:0] f, input logic [7:0] e);
      @(posedge pclk);
      {go, ch} <= {1'b1, b};
      @(posedge pclk);
      go <= 0;
      @(posedge pclk);
      #1 chk("rx", {cmd_char_valid, ctrl_cmd_valid, err_valid, cmd_char & {8{cmd_char_valid}}},
         {f, e});
   endtask : tx
   task automatic cl(input int b, input int f, input int e);
      @(posedge pclk);
      {cls_valid, cls_bits} <= {1'b1, MFE_CLS_W'(1 << b)};
      fault_flags <= f < 0 ? '0 : MFE_FLT_W'(1 << f);
      @(posedge pclk);
      cls_valid <= 0;
      #1 chk("err", {err_valid, err_code & {5{err_valid}}}, {e != 0, 5'(e)});
   endtask : cl
   task automatic tally_and_finish;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      #40000;
      failures++;
      tally_and_finish;
   end
   initial
   begin
      seed = 32'h0584_2e03;
      {psel, penable, pwrite, paddr, pwdata, go, ch, cls_valid, cls_bits, fault_flags} = 0;
      {external_clock_jumper, servo_clk_in, phase_clk_in, presetn} = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1;
      apb(1, MFE_OFS_CARD, 32'hFFFF_FFFF);
      apb(0, MFE_OFS_CARD, 0);
      chk("card", rd, 33'h0_0000_000F);
      apb(0, 8'h14, 0);
      chk("unmapped", rd, 33'h1_0000_0000);
      apb(1, MFE_OFS_CARD, 3);
      apb(1, MFE_OFS_ADDRM, MFE_MODE_ADDR);
      apb(1, MFE_OFS_ERRREP, 2);
      #1 chk("form", err_form, 2);
      tx("a", 0, 0);
      tx(MFE_CH_CR, 0, 0);
      chk("end", cmd_end, 0);
      tx("@", 0, 0);
      tx("3", 0, 0);
      tx(MFE_CH_CR, 0, 0);
      tx("x", 4, "X");
      chk("resp", resp_enable, 1);
      tx(" ", 0, 0);
      tx(MFE_CH_CR, 0, 0);
      chk("end", cmd_end, 1);
      tx("@", 0, 0);
      tx("5", 0, 0);
      tx(MFE_CH_CR, 0, 0);
      tx("a", 0, 0);
      tx(8'h12, 2, 0);
      tx(MFE_CH_CR, 0, 0);
      tx("@", 0, 0);
      tx("@", 0, 0);
      tx(MFE_CH_CR, 0, 0);
      tx("q", 4, "Q");
      chk("resp", resp_enable, 0);
      apb(0, MFE_OFS_STATUS, 0);
      chk("status", rd, 33'h0_0000_0003);
      apb(1, MFE_OFS_ADDRM, 0);
      repeat (20)
      begin
         c = {$random(seed)} % 52;
         tx(10'(c < 26 ? "a" + c : "A" + c - 26), 4, 8'("A" + c % 26));
      end
      tx(10'h085, 1, 0);
      chk("code", err_code, MFE_ERR_CHAR);
      tx(MFE_CH_CR, 0, 0);
      tx(10'h141, 1, 0);
      apb(0, MFE_OFS_LASTERR, 0);
      chk("last", rd, MFE_ERR_CHAR);
      tx(MFE_CH_CR, 0, 0);
      foreach (cb[i]) cl(cb[i], fb[i], ec[i]);
      apb(1, MFE_OFS_ERRREP, 0);
      cl(1, 0, 0);
      @(posedge pclk);
      external_clock_jumper <= 1;
      repeat (60)
      begin
         @(posedge pclk);
         {servo_clk_in, phase_clk_in} <= ~{servo_clk_in, phase_clk_in};
      end
      chk("live", shutdown, 0);
      repeat (80) @(posedge pclk);
      #1 chk("dead", {shutdown, fault_led}, 3);
      tally_and_finish;
   end
endmodule : multidrop_serial_command_frontend_test
